// ==== inc/tsi_irq_regs.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 interrupt and test-command block. Definitions only; included by bare name.
*/
`ifndef TSI_IRQ_REGS_SVH
`define TSI_IRQ_REGS_SVH

// Register offsets on the microprocessor port
`define ADDR_GLOBAL_MASK 8'h06
`define ADDR_IRQ_STATUS 8'h07
`define ADDR_IRQ_MASK 8'h08
`define ADDR_TEST_CMD 8'h09

// Global interrupt mask register
`define BIT_GIE 0
`define GIE_RESET 1'h0

// Status and mask bit positions (shared layout)
`define BIT_SYNC_FAULT 6
`define BIT_LOCKED 5
`define BIT_PAT_ERROR 3
`define BIT_SELFTEST 1
`define BIT_INJECTED 0
`define STATUS_IMPL 8'h6B
`define MASK_IMPL 8'h6B
`define MASK_FIXED_ONES 8'h14
`define MASK_RESET 8'h6B
`define STATUS_RESET 8'h00

// Test command register
`define BIT_GEN_RUN 7
`define BIT_CHK_RUN 6
`define GEN_RATE_HI 5
`define GEN_RATE_LO 4
`define CHK_RATE_HI 3
`define CHK_RATE_LO 2
`define CMD_RESET 8'h00
`define CMD_RATE_RESET 2'h0

// Rate field codes
`define RATE_CODE_2M 2'h0
`define RATE_CODE_4M 2'h1
`define RATE_CODE_8M 2'h2

// Timing
`define CLK_MHZ 200
`define FRAME_TIME_NS 125000
`define FRAME_CYCLES ((`FRAME_TIME_NS * `CLK_MHZ) / 1000)
`define LOCK_SLOTS 32
`define HIGHWAY_W 5

`endif

// ==== inc/tsi_irq_pkg.sv ====
/*
 Types shared by the interrupt and test-command block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tsi_irq_pkg;
   // Decoded highway rate of generator or checker
   typedef enum logic [1:0] {
      RATE_2M048,
      RATE_4M096,
      RATE_8M192,
      RATE_IDLE
   } rate_t;

   // Frame pulse supervision
   typedef enum logic {
      FS_HUNT,
      FS_TRACK
   } sync_state_t;
endpackage

// ==== rtl/pattern_lock_tracker.sv ====
/*
 Pattern checker lock tracker: counts error-free slots to declare lock and
 reports single errors after lock. Assumes slot strobes on the same clock.
*/
`timescale 1ns/1ps
`include "tsi_irq_regs.svh"

module pattern_lock_tracker #(
   parameter int LOCK_SLOTS = `LOCK_SLOTS
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Checker control and slot results
   input wire logic i_run,
   input wire logic i_slot_valid,
   input wire logic i_slot_error,
   // Results
   output logic o_locked,
   output logic o_lock_event,
   output logic o_error_event
);
   localparam int CW = $clog2(LOCK_SLOTS + 1);
   localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_SLOTS - 1);

   logic [CW-1:0] good_q;

   // Count consecutive error-free slots until lock
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         good_q <= '0;
         o_locked <= 1'b0;
         o_lock_event <= 1'b0;
      end else if (i_ce) begin
         o_lock_event <= 1'b0;
         if (!i_run) begin
            good_q <= '0;
            o_locked <= 1'b0;
         end else if (i_slot_valid && !o_locked) begin
            if (i_slot_error) begin
               good_q <= '0;
            end else if (good_q == LOCK_LAST) begin
               o_locked <= 1'b1; // RQ22
               o_lock_event <= 1'b1;
            end else begin
               good_q <= good_q + 1'b1;
            end
         end
      end
   end

   // Flag each errored slot once locked
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_error_event <= 1'b0;
      end else if (i_ce) begin
         o_error_event <= i_run && o_locked && i_slot_valid && i_slot_error;
      end
   end
endmodule // pattern_lock_tracker

// ==== rtl/tsi_irq_test_ctrl.sv ====
/*
 Interrupt status, mask and global enable, plus the test command register
 that runs the pattern generator and checker and sets their highway rates.
 Assumes a synchronous register port on i_clk with one-cycle read and write
 strobes, event inputs from logic on i_clk, and a frame pulse from a pin.
*/
// Operation
// RQ1: Status read clears bits until next event
// RQ2: Interrupt needs status, clear mask, enable
// RQ3: Status bits update regardless of mask
// RQ4: Sync fault mask blocks detection and interrupt
// RQ5: Implemented mask bits reset to one
// RQ6: Lock mask blocks lock interrupt
// RQ7: Error mask blocks pattern error interrupt
// RQ8: Self-test mask blocks completion interrupt
// RQ9: Injection mask blocks injection-done interrupt
// RQ10: Mask bits four and two read one
// RQ11: Reserved mask and command bits read zero
// RQ12: Command bit seven starts, stops generator
// RQ13: Command bit six starts, stops checker
// RQ14: Generator rate field decodes three rates, idle
// RQ15: Software matches generator rate to highway
// RQ16: Checker rate field uses same encoding
// RQ17: Software matches checker rate to highway
// RQ18: Generator serves one transmit highway only
// RQ19: Checker serves one selected receive highway
// RQ20: Other slots and highways stay unaffected
// RQ21: Missing or misaligned frame pulse sets fault
// RQ22: Lock after thirty-two clean slots
// RQ23: Enable low holds interrupt inactive
// RQ24: Event during status read survives clear
`timescale 1ns/1ps
`include "tsi_irq_regs.svh"

module tsi_irq_test_ctrl #(
   parameter int FRAME_CYCLES = `FRAME_CYCLES,
   parameter int LOCK_SLOTS = `LOCK_SLOTS,
   parameter int HW_W = `HIGHWAY_W
) (
   // Clock, reset, clock enable
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Event sources
   input wire logic i_frame_pulse,
   input wire logic i_slot_valid,
   input wire logic i_slot_error,
   input wire logic i_selftest_done,
   input wire logic i_inject_done,
   // Highway selection
   input wire logic [HW_W-1:0] i_gen_highway,
   input wire logic [HW_W-1:0] i_chk_highway,
   // Interrupt pin
   output logic o_irq_n,
   // Test engine control
   output logic o_generator_run,
   output logic o_checker_run,
   output tsi_irq_pkg::rate_t o_generator_rate,
   output tsi_irq_pkg::rate_t o_checker_rate,
   output logic [HW_W-1:0] o_gen_highway,
   output logic [HW_W-1:0] o_chk_highway,
   output logic o_pattern_locked
);
   import tsi_irq_pkg::*;

   localparam int FCW = $clog2(FRAME_CYCLES + 1);
   localparam logic [FCW-1:0] FRAME_LAST = FCW'(FRAME_CYCLES - 1);

   // Address match, used by every register access
   function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
      hit = (a == t);
   endfunction

   // Rate field decode, shared by generator and checker
   function automatic rate_t to_rate(input logic [1:0] code);
      unique case (code)
         `RATE_CODE_2M: to_rate = RATE_2M048;
         `RATE_CODE_4M: to_rate = RATE_4M096;
         `RATE_CODE_8M: to_rate = RATE_8M192;
         default: to_rate = RATE_IDLE;
      endcase
   endfunction

   logic gie_q;
   logic [7:0] mask_q;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic [7:0] events;
   logic [7:0] mask_view;
   logic [7:0] cmd_view;
   logic [1:0] gen_code_q;
   logic [1:0] chk_code_q;
   logic fp_meta_q;
   logic fp_sync_q;
   logic fp_prev_q;
   logic fp_rise;
   logic sync_fault;
   logic [FCW-1:0] frame_cnt_q;
   sync_state_t sync_q;
   logic lock_event;
   logic error_event;
   logic wr_mask;
   logic wr_cmd;
   logic rd_status;

   assign wr_mask = i_wr && hit(i_addr, `ADDR_IRQ_MASK);
   assign wr_cmd = i_wr && hit(i_addr, `ADDR_TEST_CMD);
   assign rd_status = i_rd && hit(i_addr, `ADDR_IRQ_STATUS);

   // Two-flop synchroniser and edge detect on the frame pulse pin
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         fp_meta_q <= 1'b0;
         fp_sync_q <= 1'b0;
         fp_prev_q <= 1'b0;
      end else if (i_ce) begin
         fp_meta_q <= i_frame_pulse;
         fp_sync_q <= fp_meta_q;
         fp_prev_q <= fp_sync_q;
      end
   end
   assign fp_rise = fp_sync_q && !fp_prev_q;

   // Frame supervision: hunt for first pulse, then expect one per frame
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sync_q <= FS_HUNT;
         frame_cnt_q <= '0;
      end else if (i_ce) begin
         if (mask_q[`BIT_SYNC_FAULT]) begin
            sync_q <= FS_HUNT; // RQ4
            frame_cnt_q <= '0;
         end else begin
            unique case (sync_q)
               FS_HUNT: begin
                  if (fp_rise) begin
                     sync_q <= FS_TRACK;
                     frame_cnt_q <= '0;
                  end
               end
               FS_TRACK: begin
                  if (fp_rise || frame_cnt_q == FRAME_LAST) begin
                     frame_cnt_q <= '0;
                  end else begin
                     frame_cnt_q <= frame_cnt_q + 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // Early pulse is misaligned, no pulse at frame end is missing
   assign sync_fault = !mask_q[`BIT_SYNC_FAULT] && sync_q == FS_TRACK &&
      (fp_rise != (frame_cnt_q == FRAME_LAST)); // RQ21 RQ4

   // Checker lock tracking
   pattern_lock_tracker #(
      .LOCK_SLOTS(LOCK_SLOTS)
   ) u_lock (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_run(o_checker_run),
      .i_slot_valid(i_slot_valid),
      .i_slot_error(i_slot_error),
      .o_locked(o_pattern_locked),
      .o_lock_event(lock_event),
      .o_error_event(error_event)
   );

   // Event vector in status layout; only sync fault depends on its mask
   always_comb begin
      events = 8'h00;
      events[`BIT_SYNC_FAULT] = sync_fault;
      events[`BIT_LOCKED] = lock_event; // RQ3
      events[`BIT_PAT_ERROR] = error_event; // RQ3
      events[`BIT_SELFTEST] = i_selftest_done; // RQ3
      events[`BIT_INJECTED] = i_inject_done; // RQ3
   end

   // Clear on read, then set; a set in the same cycle wins
   always_comb begin
      status_d = status_q;
      if (rd_status) begin
         status_d = `STATUS_RESET; // RQ1
      end
      status_d = (status_d | events) & `STATUS_IMPL; // RQ24
   end

   // Status register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         status_q <= `STATUS_RESET;
      end else if (i_ce) begin
         status_q <= status_d; // RQ1
      end
   end

   // Global enable register
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         gie_q <= `GIE_RESET;
      end else if (i_ce && i_wr && hit(i_addr, `ADDR_GLOBAL_MASK)) begin
         gie_q <= i_wdata[`BIT_GIE];
      end
   end

   // Mask register; only implemented bits are stored
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         mask_q <= `MASK_RESET; // RQ5
      end else if (i_ce && wr_mask) begin
         mask_q <= i_wdata & `MASK_IMPL;
      end
   end

   // Mask read view: fixed ones set, reserved top bit zero
   assign mask_view = mask_q | `MASK_FIXED_ONES; // RQ10 RQ11

   // Test command: run bits and rate codes
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_generator_run <= 1'b0;
         o_checker_run <= 1'b0;
         gen_code_q <= `CMD_RATE_RESET; // RQ14
         chk_code_q <= `CMD_RATE_RESET; // RQ16
      end else if (i_ce && wr_cmd) begin
         o_generator_run <= i_wdata[`BIT_GEN_RUN]; // RQ12
         o_checker_run <= i_wdata[`BIT_CHK_RUN]; // RQ13
         gen_code_q <= i_wdata[`GEN_RATE_HI:`GEN_RATE_LO];
         chk_code_q <= i_wdata[`CHK_RATE_HI:`CHK_RATE_LO];
      end
   end

   // Command read view, low reserved bits zero
   always_comb begin
      cmd_view = `CMD_RESET;
      cmd_view[`BIT_GEN_RUN] = o_generator_run;
      cmd_view[`BIT_CHK_RUN] = o_checker_run;
      cmd_view[`GEN_RATE_HI:`GEN_RATE_LO] = gen_code_q;
      cmd_view[`CHK_RATE_HI:`CHK_RATE_LO] = chk_code_q; // RQ11
   end

   // Decoded rates; software keeps them equal to the highway settings
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_generator_rate <= RATE_2M048;
         o_checker_rate <= RATE_2M048;
      end else if (i_ce) begin
         o_generator_rate <= to_rate(gen_code_q); // RQ14 RQ15
         o_checker_rate <= to_rate(chk_code_q); // RQ16 RQ17
      end
   end

   // Single highway per engine, latched while stopped so a running test
   // never moves and every other highway keeps normal switching
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_gen_highway <= '0;
         o_chk_highway <= '0;
      end else if (i_ce) begin
         if (!o_generator_run) begin
            o_gen_highway <= i_gen_highway; // RQ18 RQ20
         end
         if (!o_checker_run) begin
            o_chk_highway <= i_chk_highway; // RQ19 RQ20
         end
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_ce && i_rd) begin
         if (hit(i_addr, `ADDR_GLOBAL_MASK)) begin
            o_rdata <= {7'h00, gie_q};
         end else if (rd_status) begin
            o_rdata <= status_q;
         end else if (hit(i_addr, `ADDR_IRQ_MASK)) begin
            o_rdata <= mask_view;
         end else if (hit(i_addr, `ADDR_TEST_CMD)) begin
            o_rdata <= cmd_view;
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

   // Interrupt pin, active low: unmasked status gated by global enable
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_irq_n <= 1'b1;
      end else if (i_ce) begin
         o_irq_n <= !(gie_q && // RQ2 RQ23
            |(status_q & ~mask_q & `MASK_IMPL)); // RQ6 RQ7 RQ8 RQ9 RQ4
      end
   end
endmodule // tsi_irq_test_ctrl

// ==== sim/tsi_irq_test_ctrl_assertions.sv ====
/*
 Port checker for the interrupt and test-command block.
 Assumes one clock domain and binding to tsi_irq_test_ctrl.
*/
`timescale 1ns/1ps

module tsi_irq_test_ctrl_checker
   import tsi_irq_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register port
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Interrupt and test engine outputs
   input wire logic o_irq_n,
   input wire logic o_generator_run,
   input wire logic o_checker_run,
   input wire tsi_irq_pkg::rate_t o_generator_rate,
   input wire tsi_irq_pkg::rate_t o_checker_rate,
   input wire logic o_pattern_locked
);
   logic rd_en;
   logic cmd_wr;
   logic all_masked;
   logic gie_q;
   logic [7:0] mask_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // Qualified strobes and mask summary
   assign rd_en = i_rd && i_ce;
   assign cmd_wr = i_wr && i_ce && i_addr == 8'h09;
   assign all_masked = (mask_q & 8'h6B) == 8'h6B;

   // Mirror of the enable and mask as the host wrote them
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         gie_q <= 1'b0;
         mask_q <= 8'h6B;
      end else if (i_wr && i_ce && i_addr == 8'h06) begin
         gie_q <= i_wdata[0];
      end else if (i_wr && i_ce && i_addr == 8'h08) begin
         mask_q <= i_wdata;
      end
   end

   irq_enable_gate_a: assert property ($past(!gie_q) |-> o_irq_n)
      else $error("interrupt active while enable low");
   irq_all_masked_a: assert property ($past(all_masked) |-> o_irq_n)
      else $error("interrupt active while all sources masked");
   mask_fixed_bits_a: assert property (rd_en && i_addr == 8'h08 |=>
      o_rdata[7] == 1'b0 && o_rdata[4] && o_rdata[2])
      else $error("mask fixed bits read wrong");
   cmd_reserved_a: assert property (rd_en && i_addr == 8'h09 |=>
      o_rdata[1:0] == 2'h0)
      else $error("command low bits not zero");
   gen_rate_a: assert property (cmd_wr |->
      ##2 o_generator_rate == rate_t'($past(i_wdata[5:4], 2)))
      else $error("generator rate decode wrong");
   chk_rate_a: assert property (cmd_wr |->
      ##2 o_checker_rate == rate_t'($past(i_wdata[3:2], 2)))
      else $error("checker rate decode wrong");
   engine_run_a: assert property (cmd_wr |-> ##2 o_generator_run ==
      $past(i_wdata[7], 2) && o_checker_run == $past(i_wdata[6], 2))
      else $error("run bits do not follow command");
   lock_stop_a: assert property ($fell(o_checker_run) |->
      ##[0:2] !o_pattern_locked)
      else $error("lock kept after checker stop");
   rdata_hold_a: assert property (!rd_en |=> $stable(o_rdata))
      else $error("read data changed without read");
   unmapped_zero_a: assert property (rd_en &&
      (i_addr < 8'h06 || i_addr > 8'h09) |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule // tsi_irq_test_ctrl_checker

// ==== sim/tsi_irq_test_ctrl_test.sv ====
/*
 Self-checking bench of the interrupt and test-command block.
 Assumes short frame and lock counts set through parameters.
*/
`timescale 1ns/1ps

module tsi_irq_test_ctrl_test;
   import tsi_irq_pkg::*;
   logic i_clk, i_reset, i_wr, i_rd, o_irq_n, o_generator_run;
   logic o_checker_run, o_pattern_locked;
   logic [7:0] i_addr, i_wdata, o_rdata;
   logic [4:0] ev;
   logic ce;
   logic [4:0] gen_hw, chk_hw, o_gen_highway, o_chk_highway;
   rate_t o_generator_rate, o_checker_rate;
   rate_t exp_rate [4] = '{RATE_2M048, RATE_4M096, RATE_8M192, RATE_IDLE};
   int num_errors = 0, samples_checked = 0, cycles = 0;

   tsi_irq_test_ctrl #(.FRAME_CYCLES(64), .LOCK_SLOTS(4), .HW_W(5)) i_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_frame_pulse(ev[4]), .i_slot_valid(ev[2]), .i_slot_error(ev[3]),
      .i_selftest_done(ev[1]), .i_inject_done(ev[0]),
      .i_gen_highway(gen_hw), .i_chk_highway(chk_hw), .o_irq_n(o_irq_n),
      .o_generator_run(o_generator_run), .o_checker_run(o_checker_run),
      .o_generator_rate(o_generator_rate), .o_checker_rate(o_checker_rate),
      .o_gen_highway(o_gen_highway), .o_chk_highway(o_chk_highway),
      .o_pattern_locked(o_pattern_locked));

   // Clock at 200 MHz
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic complete_run;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run;
      end
   end

   task automatic check(input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Bus and event drivers, all moving at the falling edge
   task automatic wr(input logic [7:0] a, d);
      @(negedge i_clk);
      i_addr = a;
      i_wdata = d;
      i_wr = 1'b1;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(negedge i_clk);
      i_addr = a;
      i_rd = 1'b1;
      @(negedge i_clk);
      i_rd = 1'b0;
      check(o_rdata, exp);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(negedge i_clk);
      ev = v;
      @(negedge i_clk);
      ev = 5'h00;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic test_reset;
      rd(8'h08, 8'h7F);
      rd(8'h09, 8'h00);
      rd(8'h06, 8'h00);
      check({7'h0, o_irq_n}, 8'h01);
      $display("test_reset done");
   endtask

   task automatic test_regs;
      wr(8'h08, 8'h94);
      rd(8'h08, 8'h14);
      rd(8'h10, 8'h00);
      wr(8'h09, 8'hFF);
      idle(2);
      check({6'h0, o_generator_run, o_checker_run}, 8'h03);
      rd(8'h09, 8'hFC);
      for (int c = 0; c < 4; c++) begin
         wr(8'h09, {2'h0, 2'(c), 2'(c), 2'h0});
         idle(2);
         check({o_generator_run, o_checker_run, 2'h0, o_generator_rate,
            o_checker_rate}, {4'h0, exp_rate[c], exp_rate[c]});
      end
      $display("test_regs done");
   endtask

   task automatic test_events;
      wr(8'h08, 8'h14);
      pulse(5'h02);
      idle(2);
      check({7'h0, o_irq_n}, 8'h01);
      rd(8'h07, 8'h02);
      rd(8'h07, 8'h00);
      wr(8'h06, 8'h01);
      for (int i = 0; i < 2; i++) begin
         wr(8'h08, 8'h14 | 8'(1 << i));
         pulse(5'(1 << i));
         idle(2);
         check({7'h0, o_irq_n}, 8'h01);
         rd(8'h07, 8'(1 << i));
         wr(8'h08, 8'h14);
         pulse(5'(1 << i));
         idle(2);
         check({7'h0, o_irq_n}, 8'h00);
         rd(8'h07, 8'(1 << i));
         idle(1);
         check({7'h0, o_irq_n}, 8'h01);
      end
      // Event in the very cycle of a status read
      @(negedge i_clk);
      i_addr = 8'h07;
      i_rd = 1'b1;
      ev = 5'h02;
      @(negedge i_clk);
      i_rd = 1'b0;
      ev = 5'h00;
      rd(8'h07, 8'h02);
      $display("test_events done");
   endtask

   task automatic test_checker;
      wr(8'h09, 8'h40);
      repeat (3) pulse(5'h04);
      idle(4);
      check({7'h0, o_pattern_locked}, 8'h00);
      wr(8'h08, 8'h34);
      pulse(5'h04);
      idle(4);
      check({o_pattern_locked, o_irq_n}, 8'h03);
      rd(8'h07, 8'h20);
      wr(8'h08, 8'h1C);
      pulse(5'h0C);
      idle(4);
      check({7'h0, o_irq_n}, 8'h01);
      rd(8'h07, 8'h08);
      wr(8'h09, 8'h00);
      idle(3);
      check({o_checker_run, o_pattern_locked}, 8'h00);
      $display("test_checker done");
   endtask

   task automatic test_frame;
      wr(8'h08, 8'h7F);
      pulse(5'h10);
      idle(100);
      rd(8'h07, 8'h00);
      wr(8'h08, 8'h3F);
      pulse(5'h10);
      idle(100);
      rd(8'h07, 8'h40);
      // Early pulse inside a frame counts as misaligned
      pulse(5'h10);
      idle(5);
      rd(8'h07, 8'h40);
      $display("test_frame done");
   endtask

   // Highway choice latched only while stopped; clock enable freezes state
   task automatic test_hold;
      @(negedge i_clk);
      gen_hw = 5'h0A;
      chk_hw = 5'h15;
      idle(2);
      check({3'h0, o_gen_highway}, 8'h0A);
      check({3'h0, o_chk_highway}, 8'h15);
      wr(8'h09, 8'hC0);
      @(negedge i_clk);
      gen_hw = 5'h03;
      chk_hw = 5'h1C;
      idle(2);
      check({3'h0, o_gen_highway}, 8'h0A);
      check({3'h0, o_chk_highway}, 8'h15);
      wr(8'h09, 8'h00);
      idle(2);
      check({3'h0, o_gen_highway}, 8'h03);
      check({3'h0, o_chk_highway}, 8'h1C);
      @(negedge i_clk);
      ce = 1'b0;
      wr(8'h08, 8'h7F);
      ce = 1'b1;
      rd(8'h08, 8'h3F);
      $display("test_hold done");
   endtask

   // Main sequence
   initial begin
      i_reset = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 8'h00;
      ev = 5'h00;
      ce = 1'b1;
      gen_hw = 5'h00;
      chk_hw = 5'h00;
      idle(5);
      i_reset = 1'b0;
      test_reset;
      test_regs;
      test_events;
      test_checker;
      test_frame;
      test_hold;
      complete_run;
   end
endmodule // tsi_irq_test_ctrl_test

bind tsi_irq_test_ctrl tsi_irq_test_ctrl_checker i_checker (
   .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_irq_n(o_irq_n), .o_generator_run(o_generator_run),
   .o_checker_run(o_checker_run), .o_generator_rate(o_generator_rate),
   .o_checker_rate(o_checker_rate), .o_pattern_locked(o_pattern_locked));
